// >>> include/asrc_pkg.sv
// constants shared by the static memory controller
// assumes a 50 MHz system clock driving all controller state
package asrc_pkg;
    localparam int ADDR_W = 15;              // word address bits used
    localparam int PIN_ADDR_W = 16;          // address pins on the memory
    localparam int DATA_W = 16;              // data lines
    localparam int DEPTH = 32768;            // words in the memory
    localparam int CLK_PERIOD_NS = 20;
    // strobe widths in ns, rounded up to whole cycles
    localparam int PULSE_NS = 20;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0] LANES_OFF = 2'h3;
    typedef enum logic [2:0] {
        ASRC_IDLE  = 3'h0,
        ASRC_RSET  = 3'h1,
        ASRC_RD    = 3'h2,
        ASRC_WSET  = 3'h3,
        ASRC_WR    = 3'h4,
        ASRC_WEND  = 3'h5
    } asrc_state_t;
endpackage

// >>> verilog/asrc_ctrl.sv
// controller that drives an asynchronous 32k x 16 static memory over its pins
// assumes memory pins are wired directly; read data is sampled synchronously
// Summary of operation
// RULE1: the memory holds 32768 sixteen-bit words split in two independent byte lanes.
// RULE2: a write with the low lane select low stores the low data lane.
// RULE3: a write with the high lane select low stores the high data lane, others unchanged.
// RULE4: a read holds select and output drive low with the write strobe high.
// RULE5: during a read only lanes whose select is low are driven by the memory.
// RULE6: the memory floats its data when deselected, outputs off, lanes off or writing.
// RULE7: with select high the memory powers down and ignores the other controls.
// RULE8: a write runs while select, write strobe and a lane select are low, ending on any rise.
// RULE9: write data is held stable across the edge that ends the write.
// RULE10: select and write strobe rising together leaves the data lines floating.
// RULE11: the address is valid no later than the falling edge of select.
// RULE12: only address bits zero to fourteen are decoded; the top line is driven low.
`timescale 1ns/1ns
module asrc_ctrl #(
    parameter int PULSE = asrc_pkg::PULSE_CYC
) (
    input wire logic i_mclk,                          // system clock
    input wire logic i_nrst,                          // sync reset, active low
    input wire logic i_ce,                            // clock enable
    input wire logic i_req,                           // start an access
    input wire logic i_we,                            // 1 write, 0 read
    input wire logic [asrc_pkg::ADDR_W-1:0] i_addr,   // word address
    input wire logic [1:0] i_lane_n,                  // lane selects, bit1 high
    input wire logic [asrc_pkg::DATA_W-1:0] i_wdata,  // write data
    output logic o_busy,                              // access in progress
    output logic o_done,                              // access finished pulse
    output logic [asrc_pkg::DATA_W-1:0] o_rdata,      // read data
    output logic [asrc_pkg::PIN_ADDR_W-1:0] o_word_address_lines, // memory address
    output logic o_chip_select_n,                     // memory select
    output logic o_write_strobe_n,                    // memory write strobe
    output logic o_output_drive_n,                    // memory output drive
    output logic o_low_lane_select_n,                 // low lane select
    output logic o_high_lane_select_n,                // high lane select
    input wire logic [asrc_pkg::DATA_W-1:0] i_data_lines,  // data pins in
    output logic [asrc_pkg::DATA_W-1:0] o_data_lines,      // data pins out
    output logic o_data_lines_oe_n                    // low while driving
);
    import asrc_pkg::*;

    typedef struct packed {
        asrc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
        logic [DATA_W-1:0] rdata;
        logic [PIN_ADDR_W-1:0] addr;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [1:0] lane_n;
        logic [DATA_W-1:0] dout;
        logic dq_oe_n;
    } asrc_regs_t;

    localparam logic [CNT_W-1:0] PCNT = CNT_W'(PULSE);

    asrc_regs_t state_r;
    asrc_regs_t state_nxt;

    // nothing to do when no lane is chosen; the memory would stay idle
    function automatic logic any_lane(input logic [1:0] l);
        any_lane = (l != LANES_OFF);
    endfunction

    // next-state logic for the access sequencer
    always_comb begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        case (state_r.st)
            ASRC_IDLE: begin
                if (i_req && any_lane(i_lane_n)) begin
                    // address set before select falls [RULE11] [RULE12]
                    state_nxt.addr = {1'b0, i_addr}; // 15 bits reach every word [RULE1]
                    state_nxt.lane_n = i_lane_n;
                    state_nxt.busy = 1'b1;
                    state_nxt.cnt = PCNT;
                    if (i_we) begin
                        state_nxt.dout = i_wdata;
                        state_nxt.st = ASRC_WSET;
                    end else begin
                        state_nxt.st = ASRC_RSET;
                    end
                end
            end
            ASRC_RSET: begin
                // read: strobe high, select and output drive low [RULE4]
                state_nxt.we_n = 1'b1;
                state_nxt.cs_n = 1'b0;
                state_nxt.oe_n = 1'b0;
                state_nxt.st = ASRC_RD;
            end
            ASRC_RD: begin
                // strobes held for PULSE cycles so the access time is met
                if (state_r.cnt > 4'h1) begin
                    state_nxt.cnt = state_r.cnt - 4'h1;
                end else begin
                    // only selected lanes are valid, others zeroed [RULE5]
                    state_nxt.rdata[7:0] = state_r.lane_n[0] ? 8'h00 : i_data_lines[7:0];
                    state_nxt.rdata[15:8] = state_r.lane_n[1] ? 8'h00 : i_data_lines[15:8];
                    state_nxt.cs_n = 1'b1;
                    state_nxt.oe_n = 1'b1;
                    state_nxt.busy = 1'b0;
                    state_nxt.done = 1'b1;
                    state_nxt.st = ASRC_IDLE;
                end
            end
            ASRC_WSET: begin
                // memory floats during write, so driving is safe [RULE6]
                state_nxt.oe_n = 1'b1;
                state_nxt.dq_oe_n = 1'b0;
                state_nxt.cs_n = 1'b0;
                state_nxt.we_n = 1'b0;  // write begins with lanes low [RULE8] [RULE2] [RULE3]
                state_nxt.st = ASRC_WR;
            end
            ASRC_WR: begin
                if (state_r.cnt > 4'h1) begin
                    state_nxt.cnt = state_r.cnt - 4'h1;
                end else begin
                    // select and strobe rise together, data held one more cycle [RULE10] [RULE9]
                    state_nxt.cs_n = 1'b1;
                    state_nxt.we_n = 1'b1;
                    state_nxt.st = ASRC_WEND;
                end
            end
            ASRC_WEND: begin
                // release data after the ending edge: zero hold is met [RULE9]
                state_nxt.dq_oe_n = 1'b1;
                state_nxt.lane_n = LANES_OFF;
                state_nxt.busy = 1'b0;
                state_nxt.done = 1'b1;
                state_nxt.st = ASRC_IDLE;
            end
            default: begin
                state_nxt.st = ASRC_IDLE;
            end
        endcase
    end

    // state register; deselected memory sits in power-down [RULE7]
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_r <= '{st: ASRC_IDLE, cnt: '0, busy: 1'b0, done: 1'b0,
                         rdata: DATA_RST, addr: 16'h0000, cs_n: 1'b1, we_n: 1'b1,
                         oe_n: 1'b1, lane_n: LANES_OFF, dout: DATA_RST, dq_oe_n: 1'b1};
        end else if (i_ce) begin
            // enable low freezes pins too, so a strobe may stretch but never glitch
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state flops
    assign o_busy = state_r.busy;
    assign o_done = state_r.done;
    assign o_rdata = state_r.rdata;
    assign o_word_address_lines = state_r.addr;
    assign o_chip_select_n = state_r.cs_n;
    assign o_write_strobe_n = state_r.we_n;
    assign o_output_drive_n = state_r.oe_n;
    assign o_low_lane_select_n = state_r.lane_n[0];
    assign o_high_lane_select_n = state_r.lane_n[1];
    assign o_data_lines = state_r.dout;
    assign o_data_lines_oe_n = state_r.dq_oe_n;

    // never drive data while the memory may drive it
    no_contention_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE6]
        !(!state_r.dq_oe_n && !state_r.oe_n))
        else $error("data driven while output drive low");

    // strobe and select rise on one edge, data still driven
    wr_strobe_pair_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE10]
        $rose(state_r.we_n) |-> $rose(state_r.cs_n) && !state_r.dq_oe_n)
        else $error("write end not on select and strobe with data held");

    // address may not move while the memory is selected
    addr_stable_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE11]
        !state_r.cs_n |-> $stable(state_r.addr))
        else $error("address moved while selected");

    // unused top address line stays low
    top_addr_low_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE12]
        !state_r.addr[PIN_ADDR_W-1])
        else $error("unused address line driven high");

    // output drive only low inside a proper read
    read_ctrl_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE4]
        !state_r.oe_n |-> !state_r.cs_n && state_r.we_n && state_r.dq_oe_n)
        else $error("read controls inconsistent");

    // write strobe needs select and at least one lane
    write_lane_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE8]
        !state_r.we_n |-> !state_r.cs_n && state_r.lane_n != LANES_OFF)
        else $error("write strobe without select and lane");

    // data must outlive the strobe by one cycle
    data_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE9]
        !state_r.we_n ##1 state_r.we_n |-> !state_r.dq_oe_n && $stable(state_r.dout))
        else $error("write data not held past end");

    // done is a single-cycle pulse unless frozen
    done_one_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE5]
        state_r.done |=> !state_r.done || !i_ce)
        else $error("done pulse longer than one cycle");

    // unselected lanes read back as zero
    rd_lane_zero_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE5]
        $rose(state_r.oe_n) |-> (!state_r.lane_n[0] || state_r.rdata[7:0] == 8'h00)
            && (!state_r.lane_n[1] || state_r.rdata[15:8] == 8'h00))
        else $error("unselected read lane not zero");

    // idle means deselected: memory in standby, data pins released
    standby_idle_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE7]
        state_r.st == ASRC_IDLE |-> state_r.cs_n && state_r.we_n && state_r.oe_n
            && state_r.dq_oe_n)
        else $error("idle with memory selected or data driven");

    // data is driven on the same edge as the strobe falls
    wr_data_setup_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE9]
        $fell(state_r.we_n) |-> !state_r.dq_oe_n && state_r.oe_n)
        else $error("write started without data driven");

    // lane selects frozen for the whole selected period
    lane_stable_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE3]
        !state_r.cs_n |-> $stable(state_r.lane_n))
        else $error("lane selects moved while selected");
endmodule

// >>> dv/asrc_sram_model.sv
// behavioural 32k x 16 static memory at the far side of the pins
// assumes the bench resolves the shared data wire from the controller drive enable alone
`timescale 1ns/1ns
module asrc_sram_model (
    input wire logic [15:0] i_a,    // address lines
    input wire logic i_cs_n,        // select
    input wire logic i_we_n,        // write strobe
    input wire logic i_oe_n,        // output drive
    input wire logic [1:0] i_ln_n,  // lane selects, bit1 high
    input wire logic [15:0] i_d,    // data wire
    output logic [15:0] o_q,        // value shown on the wire
    output logic [1:0] o_en         // lanes driven
);
    logic [15:0] mem [32768];
    logic [15:0] w;
    // top address line is never decoded
    assign w = mem[i_a[14:0]];
    initial for (int k = 0; k < 32768; k++) mem[k] = 16'h0000;
    // level store while select, strobe and lane overlap; select high ignores all
    always @* begin
        if (!i_cs_n && !i_we_n && !i_ln_n[0]) mem[i_a[14:0]][7:0] = i_d[7:0];
        if (!i_cs_n && !i_we_n && !i_ln_n[1]) mem[i_a[14:0]][15:8] = i_d[15:8];
    end
    // drive only selected lanes of a read; strobe low with select keeps it floating
    assign o_en = (!i_cs_n && !i_oe_n && i_we_n) ? ~i_ln_n : 2'h0;
    // floating lanes show the inverse so a stale sample cannot pass
    assign o_q = {o_en[1] ? w[15:8] : ~w[15:8], o_en[0] ? w[7:0] : ~w[7:0]};
endmodule

// >>> dv/asrc_ctrl_tb_top.sv
// self-checking bench for asrc_ctrl against a behavioural memory
// assumes one 50 MHz clock; strobe width widened to test the count
`timescale 1ns/1ns
module asrc_ctrl_tb_top;
    import asrc_pkg::*;
    localparam int P = 2;
    logic i_mclk, i_nrst, req, we, ce;
    logic [14:0] addr;
    logic [1:0] ln;
    logic [15:0] wd;
    wire logic busy, done, cs_n, we_n, oe_n, bl_n, bh_n, doe_n;
    wire logic [15:0] rd, a, dout, q, dl;
    wire logic [1:0] en;
    int n_mismatch, comparisons, cyc;
    int rm [DEPTH];
    assign dl = !doe_n ? dout : q;
    asrc_ctrl #(.PULSE(P)) u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce),
        .i_req(req), .i_we(we), .i_addr(addr), .i_lane_n(ln), .i_wdata(wd),
        .o_busy(busy), .o_done(done), .o_rdata(rd), .o_word_address_lines(a),
        .o_chip_select_n(cs_n), .o_write_strobe_n(we_n), .o_output_drive_n(oe_n),
        .o_low_lane_select_n(bl_n), .o_high_lane_select_n(bh_n),
        .i_data_lines(dl), .o_data_lines(dout), .o_data_lines_oe_n(doe_n));
    asrc_sram_model u_mem (.i_a(a), .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_ln_n({bh_n, bl_n}), .i_d(dl), .o_q(q), .o_en(en));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic complete_run();
        $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, over ten times the expected run
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // both parties driving the wire at once is a fight
    always @(negedge i_mclk) if (doe_n === 1'b0) chk("fight", {14'h0, en}, 16'h0000);
    // one access; compares pins, latency and read data with the reference
    task automatic acc(input logic w, input logic [14:0] ad, input logic [1:0] l,
                       input logic [15:0] d);
        int n;
        logic [15:0] e;
        e = {l[1] ? 8'h00 : 8'(rm[ad] >> 8), l[0] ? 8'h00 : 8'(rm[ad])};
        @(posedge i_mclk);
        req <= 1'b1; we <= w; addr <= ad; ln <= l; wd <= d;
        @(posedge i_mclk);
        req <= 1'b0;
        // address is out one cycle before select falls
        #1;
        chk("early addr", a, {1'b0, ad});
        chk("early cs", {15'h0, cs_n}, 16'h0001);
        n = 0;
        repeat (12) begin
            @(posedge i_mclk);
            n++;
            #1;
            if (n == 1) chk("addr", a, {1'b0, ad});
            if (n == 1) chk("cs low", {15'h0, cs_n}, 16'h0000);
            if (w) chk("end pair", {15'h0, cs_n}, {15'h0, we_n});
            if (done === 1'b1) break;
        end
        chk("latency", 16'(n), 16'(w ? 2 + P : 1 + P));
        chk("idle", {14'h0, cs_n, we_n}, 16'h0003);
        if (!w) chk("rdata", rd, e);
        if (w && !l[0]) rm[ad][7:0] = d[7:0];
        if (w && !l[1]) rm[ad][15:8] = d[15:8];
    endtask
    initial begin
        i_nrst = 1'b0; req = 1'b0; we = 1'b0; addr = 15'h0000; ln = 2'h3; wd = 16'h0000;
        ce = 1'b1;
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1 chk("reset pins", {10'h0, cs_n, we_n, oe_n, bl_n, bh_n, doe_n}, 16'h003F);
        void'($urandom(50));
        acc(1'b1, 15'h7FFF, 2'h0, 16'hA55A);
        acc(1'b1, 15'h7FFF, 2'h2, 16'h1234);
        acc(1'b0, 15'h7FFF, 2'h0, 16'h0000);
        acc(1'b0, 15'h7FFF, 2'h1, 16'h0000);
        acc(1'b0, 15'h0000, 2'h0, 16'h0000);
        $display("test directed done");
        // both lanes off: the request must be ignored
        @(posedge i_mclk);
        req <= 1'b1; ln <= 2'h3;
        repeat (3) @(posedge i_mclk);
        #1 chk("refused", {15'h0, busy}, 16'h0000);
        @(posedge i_mclk);
        req <= 1'b0;
        $display("test refuse done");
        // enable low: a valid read request must start nothing
        @(posedge i_mclk);
        ce <= 1'b0;
        req <= 1'b1;
        we <= 1'b0;
        ln <= 2'h0;
        repeat (3) @(posedge i_mclk);
        #1 chk("frozen", {14'h0, busy, cs_n}, 16'h0001);
        @(posedge i_mclk);
        req <= 1'b0;
        ce <= 1'b1;
        $display("test freeze done");
        repeat (40) acc(1'($urandom), 15'($urandom % 8), 2'($urandom % 3), 16'($urandom));
        $display("test random done");
        complete_run();
    end
endmodule
